/* sim/dma_periph_model.sv */
`default_nettype none
module dma_periph_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic go,
    input wire logic [3:0] nXfer,
    input wire logic [31:0] dataIn,
    output logic xferDone,
    output logic [31:0] readData,
    output logic busy
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] left_r;
    logic phase_r;
    // one completion every second cycle, the pace of a slow peripheral
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            left_r <= 4'h0;
            phase_r <= 1'b0;
            xferDone <= 1'b0;
            readData <= 32'h0;
        end else if (left_r == 4'h0) begin
            left_r <= go ? nXfer : 4'h0;
            xferDone <= 1'b0;
            readData <= ~readData; // idle bus toggles, showing the last datum every other cycle
        end else begin
            phase_r <= ~phase_r;
            xferDone <= phase_r;
            readData <= phase_r ? dataIn : ~readData;
            if (phase_r) left_r <= left_r - 4'h1;
        end
    end
    assign busy = (left_r != 4'h0) || xferDone;
endmodule
`default_nettype wire

/* sim/dma_register_checker.sv */
`default_nettype none
module dma_register_checker #(
    parameter int NUM_CH = 4,
    parameter int ADDR_W = 32,
    parameter int DATA_W = 32,
    parameter int COUNT_W = 16
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic xferDone,
    input wire logic [$clog2(NUM_CH)-1:0] xferChan,
    input wire logic [NUM_CH-1:0] chanRequest,
    input wire logic writeAddrValid,
    input wire logic termCount,
    input wire logic ctrlDisabled,
    input wire logic ackActiveHigh,
    input wire logic [NUM_CH-1:0][7:0] chanMode
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    // command and master clear writes as complete apb accesses
    sequence cmd_wr;
        psel && penable && pwrite && paddr == 12'h000;
    endsequence
    sequence mclr_wr;
        psel && penable && pwrite && paddr == 12'h014;
    endsequence
    chk_zero_wait: assert property (psel && !penable |=> pready)
        else $error("access phase without ready");
    chk_cmd_bits: assert property (cmd_wr |=> ctrlDisabled == $past(pwdata[0]) &&
        ackActiveHigh == $past(pwdata[3])) else $error("command bits not applied");
    chk_cmd_rsvd: assert property (psel && penable && !pwrite && paddr == 12'h000
        |-> prdata[2:1] == 2'b00) else $error("reserved command bits nonzero");
    chk_mclr_cmd: assert property (mclr_wr |=> !ctrlDisabled && !ackActiveHigh)
        else $error("master clear left command set");
    chk_unmapped_err: assert property (psel && penable && paddr > 12'h038 |-> pslverr)
        else $error("unmapped access not refused");
    chk_tc_single: assert property (termCount |=> !termCount)
        else $error("terminal count longer than one cycle");
    chk_tc_cause: assert property (termCount |-> $past(xferDone))
        else $error("terminal count without transfer");
    chk_tc_masks: assert property (termCount |=> !chanRequest[$past(xferChan, 2)])
        else $error("channel still requesting after terminal count");
    chk_m2m_valid: assert property (1'b1 |-> writeAddrValid == chanMode[xferChan][0])
        else $error("write address valid mismatch");
    chk_reset_state: assert property (!$past(nrst) |-> chanRequest == '0 && !ctrlDisabled)
        else $error("state after reset wrong");
endmodule
bind dma_register_model dma_register_checker #(.NUM_CH(NUM_CH), .ADDR_W(ADDR_W),
    .DATA_W(DATA_W), .COUNT_W(COUNT_W)) u_chk (.clk(clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .xferDone(xferDone), .xferChan(xferChan),
    .chanRequest(chanRequest), .writeAddrValid(writeAddrValid), .termCount(termCount),
    .ctrlDisabled(ctrlDisabled), .ackActiveHigh(ackActiveHigh), .chanMode(chanMode));
`default_nettype wire

/* sim/multichannel_dma_register_model_tb_top.sv */
`default_nettype none
`include "dma_regs_consts.svh"
module multichannel_dma_register_model_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic nrst, psel, penable, pwrite, pready, pslverr, go, xferDone, busy, termCount;
    logic writeAddrValid, ctrlDisabled, ackActiveHigh;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, readData, dataIn, readAddr, writeAddr, rs;
    logic [3:0] hwReq, chanRequest, nXfer;
    logic [1:0] xferChan;
    logic [3:0][7:0] chanMode;
    logic [31:0] expq[$];
    int n_mismatch = 0;
    int cmp_count = 0;
    int tcSeen = 0;
    always #5 clk = ~clk;
    dma_register_model u_dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .hwReq(hwReq), .xferDone(xferDone), .xferChan(xferChan),
        .readData(readData), .chanRequest(chanRequest), .readAddr(readAddr),
        .writeAddr(writeAddr), .writeAddrValid(writeAddrValid), .termCount(termCount),
        .ctrlDisabled(ctrlDisabled), .ackActiveHigh(ackActiveHigh), .chanMode(chanMode));
    dma_periph_model u_periph (.clk(clk), .nrst(nrst), .go(go), .nXfer(nXfer),
        .dataIn(dataIn), .xferDone(xferDone), .readData(readData), .busy(busy));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // one apb transfer, request held until ready is seen at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            n_mismatch++;
            tally_and_finish();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        expq.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    // run n transfers; completion waited on under a bound
    task automatic run(input logic [3:0] n);
        int k;
        k = 0;
        rs = lfsr(rs);
        dataIn <= rs;
        nXfer <= n;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        do begin
            @(posedge clk);
            k++;
        end while (busy !== 1'b0 && k < 100);
        if (busy !== 1'b0) begin
            n_mismatch++;
            tally_and_finish();
        end
        repeat (2) @(posedge clk);
    endtask
    // read results leave the queue in issue order
    always @(posedge clk) if (psel && penable && pready && !pwrite) chk(prdata, expq.pop_front());
    always @(posedge clk) if (termCount === 1'b1) tcSeen++;
    initial begin
        {nrst, psel, penable, pwrite, go, paddr, pwdata, hwReq, nXfer, xferChan} = '0;
        dataIn = 32'h0;
        rs = 32'h165C8020;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rd(`OFS_COMMAND, 32'h0);
        rd(`OFS_CONTROL, 32'h2);
        rd(`OFS_MODE, 32'h0);
        hwReq <= 4'hF;
        @(posedge clk);
        chk(32'(chanRequest), 32'h0);
        $display("test reset done");
        rs = lfsr(rs);
        apb(1'b1, `OFS_COMMAND, rs);
        rd(`OFS_COMMAND, rs & 32'h9);
        chk(32'({ackActiveHigh, ctrlDisabled}), 32'({rs[3], rs[0]}));
        apb(1'b1, `OFS_MASTER_CLEAR, 32'h0);
        rd(`OFS_COMMAND, 32'h0);
        $display("test command done");
        apb(1'b1, `OFS_MASK_ALL, 32'h5);
        chk(32'(chanRequest), 32'hA);
        apb(1'b1, `OFS_MASK_SINGLE, 32'hFA);
        chk(32'(chanRequest), 32'hE);
        apb(1'b1, `OFS_MASK_SINGLE, 32'hFD);
        chk(32'(chanRequest), 32'hC);
        hwReq <= 4'h0;
        $display("test masks done");
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, `OFS_CHAN_SEL, 32'(c));
            apb(1'b1, `OFS_MODE, 32'h80);
            apb(1'b1, `OFS_REQ_SINGLE, 32'hFC | 32'(c));
            chk(32'(chanRequest[c]), 32'h1);
        end
        rd(`OFS_STATUS, 32'hF0);
        for (int c = 0; c < 4; c++) apb(1'b1, `OFS_REQ_SINGLE, 32'hF8 | 32'(c));
        chk(32'(chanRequest), 32'h0);
        $display("test requests done");
        apb(1'b1, `OFS_CHAN_SEL, 32'h1);
        apb(1'b1, `OFS_MODE, 32'hA5);
        rd(`OFS_MODE, 32'hA5);
        chk(32'(chanMode[1]), 32'hA5);
        apb(1'b1, `OFS_CONTROL, 32'h0);
        // aligned addresses, low byte first after clearing the pointer
        apb(1'b1, `OFS_CLEAR_PTR, 32'h0);
        for (int b = 0; b < 4; b++) apb(1'b1, `OFS_SRC_ADDR, (32'h1000 >> 8 * b) & 32'hFF);
        apb(1'b1, `OFS_CLEAR_PTR, 32'h0);
        for (int b = 0; b < 4; b++) apb(1'b1, `OFS_DST_ADDR, (32'h2000 >> 8 * b) & 32'hFF);
        apb(1'b1, `OFS_WORD_COUNT, 32'h1);
        xferChan <= 2'd1;
        @(posedge clk);
        chk(readAddr, 32'h1000);
        chk(writeAddr, 32'h2000);
        run(4'h1);
        chk(32'(tcSeen), 32'h0);
        chk(readAddr, 32'h1004);
        run(4'h1);
        chk(32'(tcSeen), 32'h1);
        chk(readAddr, 32'h1008);
        chk(writeAddr, 32'h1FF8);
        rd(`OFS_WORD_COUNT, 32'hFFFF);
        rd(`OFS_STATUS, 32'h02);
        rd(`OFS_STATUS, 32'h00);
        rd(`OFS_CONTROL, 32'h2);
        rd(`OFS_TEMP, dataIn);
        apb(1'b1, `OFS_MODE, 32'h80);
        run(4'h1);
        chk(readAddr, 32'h1008);
        chk(32'(writeAddrValid), 32'h0);
        rd(12'h0FC, 32'h0);
        $display("test transfers done");
        tally_and_finish();
    end
    // overall guard against a hang
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        tally_and_finish();
    end
endmodule
`default_nettype wire

/* verilog/dma_register_model.sv */
// The register addresses and register access over APB were left to the implementer.
`default_nettype none
`include "dma_regs_consts.svh"
module dma_register_model
    import dma_regs_pkg::*;
#(
    // channel count and the address, data and word count widths
    parameter int NUM_CH = 4,
    parameter int ADDR_W = 32,
    parameter int DATA_W = 32,
    parameter int COUNT_W = 16
) (
    input wire logic clk,
    input wire logic nrst,
    // apb slave port, zero wait states
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // transfer engine side: requests, completions and read datum
    input wire logic [NUM_CH-1:0] hwReq,
    input wire logic xferDone,
    input wire logic [$clog2(NUM_CH)-1:0] xferChan,
    input wire logic [DATA_W-1:0] readData,
    // decoded results for the transfer engine
    output logic [NUM_CH-1:0] chanRequest,
    output logic [ADDR_W-1:0] readAddr,
    output logic [ADDR_W-1:0] writeAddr,
    output logic writeAddrValid,
    output logic termCount,
    output logic ctrlDisabled,
    output logic ackActiveHigh,
    output logic [NUM_CH-1:0][7:0] chanMode
);
    // derived sizes: channel index width, bytes per address, address step
    localparam int CW = $clog2(NUM_CH);
    localparam int NBYTES = ADDR_W / 8;
    localparam int STEP = DATA_W / 8;

    // global state: command, channel select, shared byte pointer
    // a two-bit pointer limits address loads to four bytes
    logic [3:0] command_r;
    logic [CW-1:0] chanSel_r;
    logic [1:0] bytePtr_r;

    // current addresses, stepped after transfers, the destination for memory-to-memory only
    logic [NUM_CH-1:0][ADDR_W-1:0] srcAddr_r;
    logic [NUM_CH-1:0][ADDR_W-1:0] dstAddr_r;

    // base copies, not readable, kept only for the auto-init reload
    logic [NUM_CH-1:0][ADDR_W-1:0] baseSrc_r;
    logic [NUM_CH-1:0][ADDR_W-1:0] baseDst_r;

    // current and base word counts
    logic [NUM_CH-1:0][COUNT_W-1:0] count_r;
    logic [NUM_CH-1:0][COUNT_W-1:0] baseCount_r;

    // per-channel mode and control, packed field views
    mode_s [NUM_CH-1:0] mode_r;
    ctrl_s [NUM_CH-1:0] ctrl_r;

    // sticky terminal-count status, cleared by a status read
    logic [NUM_CH-1:0] tcSeen_r;

    // temporary datum, read data and terminal-count pulse
    logic [DATA_W-1:0] temp_r;
    logic [31:0] prdata_r;
    logic termCount_r;

    // access-phase decode; slave answers in the first access cycle
    logic wrEn;
    logic rdEn;
    logic masterClear;
    logic [NUM_CH-1:0] tcEvent;

    // strobes qualified by the access phase
    assign wrEn = psel & penable & pwrite;
    assign rdEn = psel & penable & ~pwrite;

    // master clear is a write strobe only, nothing is stored at its offset
    assign masterClear = wrEn && paddr == `OFS_MASTER_CLEAR;

    // zero wait states: every register answers from flops or plain decode
    assign pready = 1'b1;

    // mapped offsets are word aligned and end at the pointer register
    function automatic logic mapped(input logic [11:0] a);
        mapped = a <= `OFS_XFER_STATUS && a[1:0] == 2'b00;
    endfunction

    // error only in the access phase, so the setup cycle stays quiet
    assign pslverr = psel & penable & ~mapped(paddr);

    // address step: increment xor decrement, equal bits hold the address
    // a step past either end wraps modulo the address width
    function automatic logic [ADDR_W-1:0] stepAddr(input logic [ADDR_W-1:0] a,
                                                   input logic inc, input logic dec);
        if (inc && !dec) stepAddr = a + ADDR_W'(STEP);
        else if (dec && !inc) stepAddr = a - ADDR_W'(STEP);
        else stepAddr = a;
    endfunction

    // byte lane written in a multi-cycle address load
    // read-modify-write of one lane, the others keep their value
    function automatic logic [ADDR_W-1:0] loadByte(input logic [ADDR_W-1:0] a,
                                                   input logic [1:0] ptr, input logic [7:0] d);
        logic [ADDR_W-1:0] r;
        r = a;
        r[ptr*8 +: 8] = d;
        loadByte = r;
    endfunction

    // command register, bits 1 and 2 never stored
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            command_r <= `CMD_RESET;
        end else if (masterClear) begin
            command_r <= `CMD_RESET;
        end else if (wrEn && paddr == `OFS_COMMAND) begin
            // reserved bits forced to zero at the write
            command_r <= {pwdata[3], 2'b00, pwdata[0]};
        end
    end

    // disable and polarity are levels straight from the stored bits
    assign ctrlDisabled = command_r[`CMD_DISABLE_BIT];
    assign ackActiveHigh = command_r[`CMD_ACK_HIGH_BIT];

    // channel select and byte pointer for address loads
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            chanSel_r <= '0;
            bytePtr_r <= '0;
        end else begin
            // select picks which register set the per-channel offsets reach
            if (wrEn && paddr == `OFS_CHAN_SEL) chanSel_r <= pwdata[CW-1:0];

            // clear-pointer and master clear restart the byte sequence
            if (masterClear || (wrEn && paddr == `OFS_CLEAR_PTR)) begin
                bytePtr_r <= '0;
            end else if (wrEn && (paddr == `OFS_SRC_ADDR || paddr == `OFS_DST_ADDR)) begin
                // pointer wraps after the last byte of the address width
                bytePtr_r <= (bytePtr_r == 2'(NBYTES-1)) ? 2'b00 : bytePtr_r + 2'b01;
            end
        end
    end

    // per-channel register sets
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : gCh
            // this channel is the one the host currently addresses
            logic sel;
            // a transfer on this channel finished this cycle
            logic hit;
            // the count is at zero, so this transfer is the last one
            logic lastXfer;

            assign sel = chanSel_r == CW'(g);
            assign hit = xferDone && xferChan == CW'(g);
            assign lastXfer = count_r[g] == '0;

            // wrap from zero marks the end of service
            assign tcEvent[g] = hit && lastXfer;

            // address registers: load a byte at a time, step after transfers
            // host loads win over transfers; program only while idle
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    srcAddr_r[g] <= '0;
                    dstAddr_r[g] <= '0;
                    baseSrc_r[g] <= '0;
                    baseDst_r[g] <= '0;
                end else if (sel && wrEn && paddr == `OFS_SRC_ADDR) begin
                    srcAddr_r[g] <= loadByte(srcAddr_r[g], bytePtr_r, pwdata[7:0]);
                    baseSrc_r[g] <= loadByte(baseSrc_r[g], bytePtr_r, pwdata[7:0]);
                end else if (sel && wrEn && paddr == `OFS_DST_ADDR) begin
                    dstAddr_r[g] <= loadByte(dstAddr_r[g], bytePtr_r, pwdata[7:0]);
                    baseDst_r[g] <= loadByte(baseDst_r[g], bytePtr_r, pwdata[7:0]);
                end else if (tcEvent[g] && ctrl_r[g].autoInit) begin
                    // auto-init reload at the end of service
                    srcAddr_r[g] <= baseSrc_r[g];
                    dstAddr_r[g] <= baseDst_r[g];
                end else if (hit) begin
                    // step after each transfer
                    srcAddr_r[g] <= stepAddr(srcAddr_r[g], mode_r[g].srcInc,
                                             mode_r[g].srcDec);
                    // destination only moves for memory-to-memory
                    if (mode_r[g].memToMem) begin
                        dstAddr_r[g] <= stepAddr(dstAddr_r[g], mode_r[g].dstInc,
                                                 mode_r[g].dstDec);
                    end
                end
            end

            // word count: decrement per transfer, wrap marks terminal count
            // without auto-init the count is left at all ones after the wrap
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    count_r[g] <= '0;
                    baseCount_r[g] <= '0;
                end else if (sel && wrEn && paddr == `OFS_WORD_COUNT) begin
                    count_r[g] <= pwdata[COUNT_W-1:0];
                    baseCount_r[g] <= pwdata[COUNT_W-1:0];
                end else if (tcEvent[g] && ctrl_r[g].autoInit) begin
                    // reload the base count for the next service
                    count_r[g] <= baseCount_r[g];
                end else if (hit) begin
                    // zero counts once more, so count+1 transfers; wraps to all ones
                    count_r[g] <= count_r[g] - COUNT_W'(1);
                end
            end

            // mode register
            // master clear leaves modes alone; only reset clears them
            // a transfer type of 11 is stored as written, the engine refuses it
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    mode_r[g] <= `MODE_RESET;
                end else if (sel && wrEn && paddr == `OFS_MODE) begin
                    mode_r[g] <= pwdata[7:0];
                end
            end
            // mode fields exported for the transfer engine
            assign chanMode[g] = mode_r[g];

            // control: request, mask, auto-init; terminal count sets mask
            // later assignments win: the terminal count beats a same-cycle unmask
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    ctrl_r[g] <= `CTL_RESET;
                end else if (masterClear) begin
                    ctrl_r[g].swReq <= 1'b0;
                    ctrl_r[g].mask <= 1'b1;
                end else begin
                    // whole control word through the channel select
                    if (sel && wrEn && paddr == `OFS_CONTROL) begin
                        ctrl_r[g] <= pwdata[2:0];
                    end
                    // whole-mask write reaches the first four channels only
                    if (wrEn && paddr == `OFS_MASK_ALL && g < 4) begin
                        ctrl_r[g].mask <= pwdata[g];
                    end
                    // single-mask write, channel in bits 1:0
                    if (wrEn && paddr == `OFS_MASK_SINGLE && pwdata[1:0] == 2'(g)) begin
                        ctrl_r[g].mask <= pwdata[`SEL_SET_BIT];
                    end
                    // single request write, channel in bits 1:0
                    if (wrEn && paddr == `OFS_REQ_SINGLE && pwdata[1:0] == 2'(g)) begin
                        ctrl_r[g].swReq <= pwdata[`SEL_SET_BIT];
                    end
                    // end of service drops the request and masks the channel
                    if (tcEvent[g]) begin
                        ctrl_r[g].swReq <= 1'b0;
                        ctrl_r[g].mask <= 1'b1;
                    end
                end
            end

            // terminal-count flag, set wins over the clearing status read
            // so a wrap in the read's access cycle is never lost
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    tcSeen_r[g] <= 1'b0;
                end else if (tcEvent[g]) begin
                    tcSeen_r[g] <= 1'b1;
                end else if (masterClear || (rdEn && paddr == `OFS_STATUS)) begin
                    tcSeen_r[g] <= 1'b0;
                end
            end

            // software requests ignore the mask
            // hardware requests are levels on this clock, so no synchroniser
            assign chanRequest[g] = ctrl_r[g].swReq | (hwReq[g] & ~ctrl_r[g].mask);
        end
    endgenerate

    // temporary register holds the last memory-to-memory datum
    // master clear empties it along with the command register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            temp_r <= '0;
        end else if (masterClear) begin
            temp_r <= '0;
        end else if (xferDone && mode_r[xferChan].memToMem) begin
            temp_r <= readData;
        end
    end

    // addresses for the active channel
    // always driven; the valid flag says whether the destination is used
    always_comb begin
        readAddr = srcAddr_r[xferChan];
        writeAddr = dstAddr_r[xferChan];
        writeAddrValid = mode_r[xferChan].memToMem;
    end

    // terminal-count pulse registered one cycle after the wrap
    // registered to stay glitch-free, at the cost of one cycle of latency
    // every channel's wrap drives the one shared output
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            termCount_r <= 1'b0;
        end else begin
            termCount_r <= |tcEvent;
        end
    end
    assign termCount = termCount_r;

    // read mux; status shows only the first four channels
    // per-channel registers are read through the channel select
    logic [31:0] rdMux;
    always_comb begin
        rdMux = 32'h0000_0000;
        case (paddr)
            `OFS_COMMAND: rdMux = {28'h0, command_r};
            // status: terminal counts in the low nibble, requests above
            `OFS_STATUS: begin
                for (int i = 0; i < 4 && i < NUM_CH; i++) begin
                    rdMux[i] = tcSeen_r[i];
                    rdMux[i+4] = chanRequest[i];
                end
            end
            `OFS_TEMP: rdMux = 32'(temp_r);
            `OFS_CHAN_SEL: rdMux = 32'(chanSel_r);
            `OFS_SRC_ADDR: rdMux = 32'(srcAddr_r[chanSel_r]);
            `OFS_DST_ADDR: rdMux = 32'(dstAddr_r[chanSel_r]);
            `OFS_WORD_COUNT: rdMux = 32'(count_r[chanSel_r]);
            `OFS_MODE: rdMux = {24'h0, mode_r[chanSel_r]};
            `OFS_CONTROL: rdMux = {29'h0, ctrl_r[chanSel_r]};
            `OFS_XFER_STATUS: rdMux = {30'h0, bytePtr_r};
            // write-only and unmapped offsets read as zero
            default: rdMux = 32'h0000_0000;
        endcase
    end

    // capture read data in the setup cycle so it stands in the access cycle
    // access-phase side effects, like the status clear, cannot disturb it
    // other cycles keep the last captured word
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prdata_r <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata_r <= rdMux;
        end
    end
    assign prdata = prdata_r;
endmodule
`default_nettype wire

/* verilog/dma_regs_consts.svh */
`ifndef DMA_REGS_CONSTS_SVH
`define DMA_REGS_CONSTS_SVH
// register byte offsets on the apb window
`define OFS_COMMAND 12'h000
`define OFS_MASK_ALL 12'h004
`define OFS_MASK_SINGLE 12'h008
`define OFS_REQ_SINGLE 12'h00C
`define OFS_STATUS 12'h010
`define OFS_MASTER_CLEAR 12'h014
`define OFS_CLEAR_PTR 12'h018
`define OFS_TEMP 12'h01C
`define OFS_CHAN_SEL 12'h020
`define OFS_SRC_ADDR 12'h024
`define OFS_DST_ADDR 12'h028
`define OFS_WORD_COUNT 12'h02C
`define OFS_MODE 12'h030
`define OFS_CONTROL 12'h034
`define OFS_XFER_STATUS 12'h038
// field positions
`define CMD_DISABLE_BIT 0
`define CMD_ACK_HIGH_BIT 3
`define MODE_MEM2MEM_BIT 0
`define MODE_READ_BIT 1
`define MODE_SRC_INC_BIT 2
`define MODE_SRC_DEC_BIT 3
`define MODE_DST_INC_BIT 4
`define MODE_DST_DEC_BIT 5
`define CTL_SWREQ_BIT 0
`define CTL_MASK_BIT 1
`define CTL_AUTO_BIT 2
`define SEL_SET_BIT 2
// reset values
`define CMD_RESET 4'h0
`define MODE_RESET 8'h00
`define CTL_RESET 3'h2
`endif

/* verilog/dma_regs_pkg.sv */
`default_nettype none
package dma_regs_pkg;
    typedef enum logic [1:0] {XFER_DEMAND, XFER_SINGLE, XFER_BLOCK, XFER_ILLEGAL} xfer_mode_e;
    // per-channel mode fields in hardware bit order
    typedef struct packed {
        xfer_mode_e xferMode;
        logic dstDec;
        logic dstInc;
        logic srcDec;
        logic srcInc;
        logic readXfer;
        logic memToMem;
    } mode_s;
    typedef struct packed {
        logic autoInit;
        logic mask;
        logic swReq;
    } ctrl_s;
endpackage
`default_nettype wire
